//--- core/stream_checksum_offload.v
// Stream framing with partial transmit and raw receive checksum offload.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`include "stream_checksum_offload_defines.vh"

// Overview of operation
// - Transmit sum starts at aligned start offset.
// - Enable bits 1:0 must equal one for insertion.
// - Per-frame seed joins the transmit sum.
// - UDP zero result is sent as ones.
// - Raw receive sum from byte fourteen onward.
// - Unstripped FCS bytes join the raw sum.
// - Packets end with TLAST on final word.
// - Full strobes on every word but last.
// - Last word packs bytes from lane zero.
// - Works with strobes tied to one.
// - Sender pauses by dropping TVALID.
// - Receiver pauses by dropping TREADY.
// - Separate data, control and status streams.
// - Streams share clock, not frame alignment.
// - Control flag nibble selects or ignores packet.
// - Receive status uses one fixed format.
// - Word two carries start and insert offsets.
// - Word one bits 1:0 select offload.
// - Word three low half carries seed.
module stream_checksum_offload #(
   parameter ADDR_W = 9
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire s_ctl_tvalid_i,
   input wire [31:0] s_ctl_tdata_i,
   input wire [3:0] s_ctl_tstrb_i,
   input wire s_ctl_tlast_i,
   output reg s_ctl_tready_o,
   input wire s_txd_tvalid_i,
   input wire [31:0] s_txd_tdata_i,
   input wire [3:0] s_txd_tstrb_i,
   input wire s_txd_tlast_i,
   output reg s_txd_tready_o,
   output reg m_txd_tvalid_o,
   output reg [31:0] m_txd_tdata_o,
   output reg [3:0] m_txd_tstrb_o,
   output reg m_txd_tlast_o,
   input wire m_txd_tready_i,
   input wire s_rxd_tvalid_i,
   input wire [31:0] s_rxd_tdata_i,
   input wire [3:0] s_rxd_tstrb_i,
   input wire s_rxd_tlast_i,
   output reg s_rxd_tready_o,
   output reg m_rxd_tvalid_o,
   output reg [31:0] m_rxd_tdata_o,
   output reg [3:0] m_rxd_tstrb_o,
   output reg m_rxd_tlast_o,
   input wire m_rxd_tready_i,
   output reg m_sts_tvalid_o,
   output reg [31:0] m_sts_tdata_o,
   output reg [3:0] m_sts_tstrb_o,
   output reg m_sts_tlast_o,
   input wire m_sts_tready_i
);

   localparam CNT_W = ADDR_W + 1;
   localparam DEPTH = 1 << ADDR_W;
   localparam [1:0] S_CTL = 2'h0;
   localparam [1:0] S_DATA = 2'h1;
   localparam [1:0] S_FIN = 2'h2;
   localparam [1:0] S_SEND = 2'h3;

   function [2:0] popcount;
      input [3:0] s;
      begin
         popcount = {2'b00, s[0]} + {2'b00, s[1]} + {2'b00, s[2]} +
            {2'b00, s[3]};
      end
   endfunction

   // -------------------------------------------------------------------
   // Register bus
   // -------------------------------------------------------------------
   reg [1:0] ctrl_q;
   reg [15:0] tx_sum_last_q;
   reg [15:0] rx_raw_sum_q;
   reg [15:0] rx_bytes_q;
   reg [1:0] state_q;
   reg sts_pend_q;
   wire wb_req = wb_cyc_i && wb_stb_i;

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_q <= `CTRL_RESET;
      end else begin
         wb_ack_o <= wb_req && !wb_ack_o;
         // The write lands on the edge at which the master sees ack.
         if (wb_req && wb_we_i && wb_ack_o && wb_sel_i[0] &&
               wb_adr_i == `REG_CTRL_OFF) begin
            ctrl_q <= wb_dat_i[1:0];
         end
         case (wb_adr_i)
            `REG_CTRL_OFF: wb_dat_o <= {30'h0, ctrl_q};
            `REG_STATUS_OFF: wb_dat_o <= {rx_bytes_q, 13'h0, sts_pend_q,
               state_q};
            `REG_TX_SUM_OFF: wb_dat_o <= {16'h0000, tx_sum_last_q};
            `REG_RX_SUM_OFF: wb_dat_o <= {16'h0000, rx_raw_sum_q};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Transmit control stream and frame store
   // -------------------------------------------------------------------
   reg [31:0] mem [0:DEPTH-1];
   reg [2:0] ctl_idx_q;
   reg [3:0] flag_q;
   reg [15:0] tx_sum_insert_enable_q;
   reg [15:0] tx_sum_start_offset_q;
   reg [15:0] tx_sum_insert_offset_q;
   reg [15:0] tx_sum_seed_q;
   reg [15:0] tx_sum_q;
   reg [15:0] final_q;
   reg [CNT_W-1:0] wr_cnt_q;
   reg [CNT_W-1:0] rd_idx_q;
   reg [3:0] last_strb_q;
   reg ipv4_q;
   reg udp_q;

   wire ctl_acc = s_ctl_tvalid_i && s_ctl_tready_o;
   wire txd_acc = s_txd_tvalid_i && s_txd_tready_o;
   // The tag nibble of a one-word packet is still on the bus.
   wire [3:0] cur_flag = (ctl_idx_q == `CTL_IDX_TAG) ?
      s_ctl_tdata_i[31:28] : flag_q;
   wire flag_known = (cur_flag == `FLAG_NORMAL_TX) ||
      (cur_flag == `FLAG_RX_STATUS);
   // Loop-back status frames never get offload.
   wire sum_active = (flag_q == `FLAG_NORMAL_TX) && ctrl_q[`CTRL_TX_EN_BIT]
      && (tx_sum_insert_enable_q[1:0] == `OFFLOAD_PARTIAL);
   wire ins_active = sum_active && tx_sum_insert_enable_q[0];
   wire [13:0] wr_word = {{(14-CNT_W){1'b0}}, wr_cnt_q};
   wire [13:0] rd_word = {{(14-CNT_W){1'b0}}, rd_idx_q};
   wire store_ok = (wr_cnt_q != DEPTH[CNT_W-1:0]);
   wire [15:0] tx_sum_next;
   wire [15:0] tx_csum;

   csum_word_add tx_adder (
      .sum_i(tx_sum_q),
      .data_i(s_txd_tdata_i),
      .strb_i(s_txd_tstrb_i),
      .offset_i({wr_word, 2'b00}),
      .start_i(tx_sum_start_offset_q),
      .en_i(sum_active && store_ok),
      .sum_o(tx_sum_next)
   );

   csum_finish tx_finisher (
      .sum_i(tx_sum_q),
      .seed_i(tx_sum_seed_q),
      .is_udp_i(udp_q),
      .csum_o(tx_csum)
   );

   // Overlays the checksum big-endian at the insert offset.
   function [31:0] insert_sum;
      input [31:0] w;
      input hit;
      input upper;
      input [15:0] c;
      begin
         insert_sum = w;
         if (hit && upper) begin
            insert_sum = {c[7:0], c[15:8], w[15:0]};
         end else if (hit) begin
            insert_sum = {w[31:16], c[7:0], c[15:8]};
         end
      end
   endfunction

   wire ins_hit = ins_active &&
      (tx_sum_insert_offset_q[15:2] == rd_word);
   wire rd_more = (rd_idx_q != wr_cnt_q);
   wire slot_free = !m_txd_tvalid_o || m_txd_tready_i;
   wire tx_load = (state_q == S_SEND) && rd_more && slot_free;
   wire rd_last = (rd_idx_q + {{(CNT_W-1){1'b0}}, 1'b1}) == wr_cnt_q;

   always @(posedge clk_i) begin
      if (tx_load) begin
         m_txd_tdata_o <= insert_sum(mem[rd_idx_q[ADDR_W-1:0]], ins_hit,
            tx_sum_insert_offset_q[1], final_q);
         m_txd_tstrb_o <= rd_last ? last_strb_q : 4'hf;
         m_txd_tlast_o <= rd_last;
      end
      if (txd_acc && store_ok) begin
         mem[wr_cnt_q[ADDR_W-1:0]] <= s_txd_tdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_CTL;
         s_ctl_tready_o <= 1'b1;
         s_txd_tready_o <= 1'b0;
         m_txd_tvalid_o <= 1'b0;
         ctl_idx_q <= 3'h0;
         flag_q <= 4'h0;
         tx_sum_insert_enable_q <= 16'h0000;
         tx_sum_start_offset_q <= 16'h0000;
         tx_sum_insert_offset_q <= 16'h0000;
         tx_sum_seed_q <= 16'h0000;
         tx_sum_q <= 16'h0000;
         final_q <= 16'h0000;
         tx_sum_last_q <= 16'h0000;
         wr_cnt_q <= {CNT_W{1'b0}};
         rd_idx_q <= {CNT_W{1'b0}};
         last_strb_q <= 4'hf;
         ipv4_q <= 1'b0;
         udp_q <= 1'b0;
      end else begin
         if (tx_load) begin
            m_txd_tvalid_o <= 1'b1;
         end else if (m_txd_tready_i) begin
            m_txd_tvalid_o <= 1'b0;
         end
         case (state_q)
            S_CTL: begin
               // Data stays refused until its control packet is in.
               if (ctl_acc) begin
                  if (ctl_idx_q != 3'h7) begin
                     ctl_idx_q <= ctl_idx_q + 3'h1;
                  end
                  case (ctl_idx_q)
                     `CTL_IDX_TAG: flag_q <= s_ctl_tdata_i[31:28];
                     `CTL_IDX_SELECT:
                        tx_sum_insert_enable_q <= s_ctl_tdata_i[15:0];
                     `CTL_IDX_OFFSETS: begin
                        tx_sum_start_offset_q <= s_ctl_tdata_i[31:16];
                        tx_sum_insert_offset_q <= s_ctl_tdata_i[15:0];
                     end
                     `CTL_IDX_SEED: tx_sum_seed_q <= s_ctl_tdata_i[15:0];
                     default: ;
                  endcase
                  if (s_ctl_tlast_i) begin
                     ctl_idx_q <= 3'h0;
                     // Unknown tags drop the control packet alone.
                     if (flag_known) begin
                        state_q <= S_DATA;
                        s_ctl_tready_o <= 1'b0;
                        s_txd_tready_o <= 1'b1;
                        tx_sum_q <= 16'h0000;
                        wr_cnt_q <= {CNT_W{1'b0}};
                        ipv4_q <= 1'b0;
                        udp_q <= 1'b0;
                     end
                  end
               end
            end
            S_DATA: begin
               if (txd_acc) begin
                  // Words past the store depth are discarded.
                  if (store_ok) begin
                     wr_cnt_q <= wr_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                     tx_sum_q <= tx_sum_next;
                  end
                  if (wr_word == `ETHERTYPE_WORD) begin
                     ipv4_q <= {s_txd_tdata_i[7:0], s_txd_tdata_i[15:8]}
                        == `ETHERTYPE_IPV4;
                  end
                  if (wr_word == `IP_PROTO_WORD) begin
                     udp_q <= ipv4_q &&
                        (s_txd_tdata_i[31:24] == `IP_PROTO_UDP);
                  end
                  if (s_txd_tlast_i) begin
                     last_strb_q <= s_txd_tstrb_i;
                     s_txd_tready_o <= 1'b0;
                     state_q <= S_FIN;
                  end
               end
            end
            S_FIN: begin
               final_q <= tx_csum;
               tx_sum_last_q <= tx_csum;
               rd_idx_q <= {CNT_W{1'b0}};
               state_q <= S_SEND;
            end
            S_SEND: begin
               if (tx_load) begin
                  rd_idx_q <= rd_idx_q + {{(CNT_W-1){1'b0}}, 1'b1};
               end else if (!rd_more && slot_free) begin
                  state_q <= S_CTL;
                  s_ctl_tready_o <= 1'b1;
               end
            end
            default: state_q <= S_CTL;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Receive data pass-through, raw sum and status stream
   // -------------------------------------------------------------------
   reg [13:0] rx_word_q;
   reg [15:0] rx_sum_q;
   reg [15:0] rx_cnt_q;
   reg [2:0] sts_idx_q;
   reg rv_d;
   reg pend_d;
   wire [15:0] rx_sum_next;
   wire rx_acc = s_rxd_tvalid_i && s_rxd_tready_o;
   wire sts_free = !m_sts_tvalid_o || m_sts_tready_i;
   wire sts_load = sts_pend_q && sts_free && (sts_idx_q != `STS_WORDS);
   wire sts_done = sts_pend_q && (sts_idx_q == `STS_WORDS);
   wire [15:0] rx_cnt_next = rx_cnt_q + (s_rxd_tlast_i ?
      {13'h0, popcount(s_rxd_tstrb_i)} : 16'h0004);

   // Every byte through TLAST counts, so an unstripped FCS is included.
   csum_word_add rx_adder (
      .sum_i(rx_sum_q),
      .data_i(s_rxd_tdata_i),
      .strb_i(s_rxd_tstrb_i),
      .offset_i({rx_word_q, 2'b00}),
      .start_i(`RX_SUM_START),
      .en_i(ctrl_q[`CTRL_RX_EN_BIT]),
      .sum_o(rx_sum_next)
   );

   function [31:0] sts_word;
      input [2:0] idx;
      input [15:0] raw;
      input [15:0] len;
      begin
         case (idx)
            3'h0: sts_word = `STS_TAG_WORD;
            3'h1: sts_word = {16'h0000, raw};
            3'h2: sts_word = {16'h0000, len};
            default: sts_word = 32'h0000_0000;
         endcase
      end
   endfunction

   always @* begin
      rv_d = m_rxd_tvalid_o && !m_rxd_tready_i;
      pend_d = sts_pend_q && !sts_done;
      if (rx_acc) begin
         rv_d = 1'b1;
         pend_d = pend_d || s_rxd_tlast_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         s_rxd_tready_o <= 1'b0;
         m_rxd_tvalid_o <= 1'b0;
         m_rxd_tdata_o <= 32'h0000_0000;
         m_rxd_tstrb_o <= 4'h0;
         m_rxd_tlast_o <= 1'b0;
         m_sts_tvalid_o <= 1'b0;
         m_sts_tdata_o <= 32'h0000_0000;
         m_sts_tstrb_o <= 4'hf;
         m_sts_tlast_o <= 1'b0;
         rx_word_q <= 14'h0000;
         rx_sum_q <= 16'h0000;
         rx_cnt_q <= 16'h0000;
         rx_raw_sum_q <= 16'h0000;
         rx_bytes_q <= 16'h0000;
         sts_pend_q <= 1'b0;
         sts_idx_q <= 3'h0;
      end else begin
         m_rxd_tvalid_o <= rv_d;
         sts_pend_q <= pend_d;
         // A finished frame waits for its status before the next one.
         s_rxd_tready_o <= !rv_d && !pend_d;
         if (rx_acc) begin
            m_rxd_tdata_o <= s_rxd_tdata_i;
            m_rxd_tstrb_o <= s_rxd_tstrb_i;
            m_rxd_tlast_o <= s_rxd_tlast_i;
            if (s_rxd_tlast_i) begin
               rx_raw_sum_q <= rx_sum_next;
               rx_bytes_q <= rx_cnt_next;
               rx_word_q <= 14'h0000;
               rx_sum_q <= 16'h0000;
               rx_cnt_q <= 16'h0000;
            end else begin
               rx_word_q <= rx_word_q + 14'h0001;
               rx_sum_q <= rx_sum_next;
               rx_cnt_q <= rx_cnt_next;
            end
         end
         if (sts_load) begin
            m_sts_tvalid_o <= 1'b1;
            m_sts_tdata_o <= sts_word(sts_idx_q, rx_raw_sum_q, rx_bytes_q);
            m_sts_tstrb_o <= 4'hf;
            m_sts_tlast_o <= (sts_idx_q == `STS_LAST_IDX);
            sts_idx_q <= sts_idx_q + 3'h1;
         end else if (m_sts_tready_i) begin
            m_sts_tvalid_o <= 1'b0;
         end
         if (sts_done) begin
            sts_idx_q <= 3'h0;
         end
      end
   end

endmodule

//--- core/stream_checksum_offload_defines.vh
// Constants for the stream checksum offload block.
`ifndef STREAM_CHECKSUM_OFFLOAD_DEFINES_VH
`define STREAM_CHECKSUM_OFFLOAD_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define REG_CTRL_OFF 8'h00
`define REG_STATUS_OFF 8'h04
`define REG_TX_SUM_OFF 8'h08
`define REG_RX_SUM_OFF 8'h0c

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define CTRL_TX_EN_BIT 0
`define CTRL_RX_EN_BIT 1
`define CTRL_RESET 2'h3

// ----------------------------------------------------------------------
// Control stream words and fields
// ----------------------------------------------------------------------
`define FLAG_NORMAL_TX 4'ha
`define FLAG_RX_STATUS 4'h5
`define CTL_IDX_TAG 3'h0
`define CTL_IDX_SELECT 3'h1
`define CTL_IDX_OFFSETS 3'h2
`define CTL_IDX_SEED 3'h3
`define OFFLOAD_PARTIAL 2'h1

// ----------------------------------------------------------------------
// Frame layout and receive status format
// ----------------------------------------------------------------------
`define RX_SUM_START 16'h000e
`define ETHERTYPE_IPV4 16'h0800
`define IP_PROTO_UDP 8'h11
`define ETHERTYPE_WORD 14'h0003
`define IP_PROTO_WORD 14'h0005
`define STS_LAST_IDX 3'h5
`define STS_WORDS 3'h6
`define STS_TAG_WORD 32'h5000_0000

`endif

//--- core/csum_word_add.v
// One's complement addition of one stream word into a running checksum.
module csum_word_add (
   input wire [15:0] sum_i,
   input wire [31:0] data_i,
   input wire [3:0] strb_i,
   input wire [15:0] offset_i,
   input wire [15:0] start_i,
   input wire en_i,
   output wire [15:0] sum_o
);

   function [15:0] oc_add;
      input [15:0] a;
      input [15:0] b;
      reg [16:0] t;
      begin
         t = {1'b0, a} + {1'b0, b};
         oc_add = t[15:0] + {15'h0000, t[16]};
      end
   endfunction

   wire [7:0] b0 = strb_i[0] ? data_i[7:0] : 8'h00;
   wire [7:0] b1 = strb_i[1] ? data_i[15:8] : 8'h00;
   wire [7:0] b2 = strb_i[2] ? data_i[23:16] : 8'h00;
   wire [7:0] b3 = strb_i[3] ? data_i[31:24] : 8'h00;
   wire [16:0] off_hi = {1'b0, offset_i} + 17'h00002;
   // Lane 0 holds the lower frame offset, so it is the high byte of a pair.
   wire use_lo = en_i && (offset_i >= start_i);
   wire use_hi = en_i && (off_hi >= {1'b0, start_i});
   wire [15:0] s1 = oc_add(sum_i, use_lo ? {b0, b1} : 16'h0000);

   assign sum_o = oc_add(s1, use_hi ? {b2, b3} : 16'h0000);

endmodule

//--- core/csum_finish.v
// Folds the seed into a transmit sum and forms the value to insert.
module csum_finish (
   input wire [15:0] sum_i,
   input wire [15:0] seed_i,
   input wire is_udp_i,
   output wire [15:0] csum_o
);

   wire [16:0] t = {1'b0, sum_i} + {1'b0, seed_i};
   wire [15:0] folded = t[15:0] + {15'h0000, t[16]};
   wire [15:0] inv = ~folded;

   // A zero UDP checksum means none was computed, so all ones is sent.
   assign csum_o = (is_udp_i && inv == 16'h0000) ? 16'hffff : inv;

endmodule

//--- verification/stream_sink_model.sv
// Far-side sink model that throttles the three output streams.
module stream_sink_model (
   input wire logic clk_i,
   input wire logic slow_i,
   output logic txd_rdy_o = 1'h1,
   output logic rxd_rdy_o = 1'h1,
   output logic sts_rdy_o = 1'h1
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] n_q = 3'h0;

   // Slow mode stalls each stream on its own pattern.
   always @(posedge clk_i) begin
      n_q <= n_q + 3'h1;
      txd_rdy_o <= !slow_i || n_q[0];
      rxd_rdy_o <= !slow_i || n_q[1];
      sts_rdy_o <= !slow_i || n_q[2];
   end
endmodule

//--- verification/stream_checksum_offload_monitor.sv
// Stream protocol checker bound to the checksum offload block.
module stream_checksum_offload_check (
   input wire clk_i,
   input wire rst_i,
   input wire s_ctl_tready_o,
   input wire s_txd_tready_o,
   input wire s_rxd_tvalid_i,
   input wire [31:0] s_rxd_tdata_i,
   input wire s_rxd_tlast_i,
   input wire s_rxd_tready_o,
   input wire m_txd_tvalid_o,
   input wire [31:0] m_txd_tdata_o,
   input wire [3:0] m_txd_tstrb_o,
   input wire m_txd_tlast_o,
   input wire m_txd_tready_i,
   input wire m_rxd_tvalid_o,
   input wire [31:0] m_rxd_tdata_o,
   input wire m_rxd_tlast_o,
   input wire m_rxd_tready_i,
   input wire m_sts_tvalid_o,
   input wire [31:0] m_sts_tdata_o,
   input wire [3:0] m_sts_tstrb_o,
   input wire m_sts_tlast_o,
   input wire m_sts_tready_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] sts_cnt_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         sts_cnt_q <= 3'h0;
      end else if (m_sts_tvalid_o && m_sts_tready_i) begin
         sts_cnt_q <= m_sts_tlast_o ? 3'h0 : sts_cnt_q + 3'h1;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_txd_hold;
      m_txd_tvalid_o && !m_txd_tready_i |=> m_txd_tvalid_o &&
         $stable({m_txd_tdata_o, m_txd_tstrb_o, m_txd_tlast_o});
   endproperty
   a_txd_hold: assert property (p_txd_hold)
      else $error("transmit word changed while stalled");
   property p_rxd_hold;
      m_rxd_tvalid_o && !m_rxd_tready_i |=> m_rxd_tvalid_o &&
         $stable({m_rxd_tdata_o, m_rxd_tlast_o});
   endproperty
   a_rxd_hold: assert property (p_rxd_hold)
      else $error("receive word changed while stalled");
   property p_sts_hold;
      m_sts_tvalid_o && !m_sts_tready_i |=> m_sts_tvalid_o &&
         $stable({m_sts_tdata_o, m_sts_tlast_o});
   endproperty
   a_sts_hold: assert property (p_sts_hold)
      else $error("status word changed while stalled");
   property p_txd_strb;
      m_txd_tvalid_o |-> (m_txd_tlast_o ?
         m_txd_tstrb_o inside {4'h1, 4'h3, 4'h7, 4'hf} :
         m_txd_tstrb_o == 4'hf);
   endproperty
   a_txd_strb: assert property (p_txd_strb)
      else $error("transmit strobes not aligned");
   property p_tx_excl;
      s_txd_tready_o |-> !s_ctl_tready_o;
   endproperty
   a_tx_excl: assert property (p_tx_excl)
      else $error("control and data ready together");
   property p_rx_pass;
      s_rxd_tvalid_i && s_rxd_tready_o |=> m_rxd_tvalid_o &&
         m_rxd_tdata_o == $past(s_rxd_tdata_i) &&
         m_rxd_tlast_o == $past(s_rxd_tlast_i);
   endproperty
   a_rx_pass: assert property (p_rx_pass)
      else $error("receive word not passed on");
   property p_sts_form;
      m_sts_tvalid_o |-> m_sts_tstrb_o == 4'hf &&
         m_sts_tlast_o == (sts_cnt_q == 3'h5) &&
         (sts_cnt_q != 3'h0 || m_sts_tdata_o == 32'h5000_0000);
   endproperty
   a_sts_form: assert property (p_sts_form)
      else $error("status packet format wrong");
   property p_sts_soon;
      s_rxd_tvalid_i && s_rxd_tready_o && s_rxd_tlast_i |->
         ##[1:40] m_sts_tvalid_o;
   endproperty
   a_sts_soon: assert property (p_sts_soon)
      else $error("status did not follow frame");

   c_tx_last: cover property (m_txd_tvalid_o && m_txd_tready_i &&
      m_txd_tlast_o);
   c_sts_last: cover property (m_sts_tvalid_o && m_sts_tready_i &&
      m_sts_tlast_o);
   c_tx_stall: cover property (m_txd_tvalid_o && !m_txd_tready_i);
endmodule

bind stream_checksum_offload stream_checksum_offload_check i_chk (.*);

//--- verification/stream_checksum_offload_bench.sv
// Self-checking bench for the stream checksum offload block.
module stream_checksum_offload_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic s_ctl_tvalid_i = 1'h0, s_ctl_tlast_i = 1'h0, s_ctl_tready_o;
   logic s_txd_tvalid_i = 1'h0, s_txd_tlast_i = 1'h0, s_txd_tready_o;
   logic s_rxd_tvalid_i = 1'h0, s_rxd_tlast_i = 1'h0, s_rxd_tready_o;
   logic [31:0] s_ctl_tdata_i = 32'h0, s_txd_tdata_i = 32'h0;
   logic [31:0] s_rxd_tdata_i = 32'h0;
   logic [3:0] s_txd_tstrb_i = 4'hf, s_rxd_tstrb_i = 4'hf;
   logic m_txd_tvalid_o, m_txd_tlast_o, m_txd_tready_i;
   logic m_rxd_tvalid_o, m_rxd_tlast_o, m_rxd_tready_i;
   logic m_sts_tvalid_o, m_sts_tlast_o, m_sts_tready_i;
   logic [31:0] m_txd_tdata_o, m_rxd_tdata_o, m_sts_tdata_o;
   logic [3:0] m_txd_tstrb_o, m_rxd_tstrb_o, m_sts_tstrb_o;
   logic slow = 1'h0;
   logic [1:0] en = 2'h3;
   logic [15:0] lf = 16'h22f3;
   logic [7:0] fr[0:63], ex[0:63];
   logic [36:0] tq[$], rq[$], sq[$];
   int n_fail = 0, comparisons = 0;

   function [15:0] rnd();
      lf = lf[0] ? (lf >> 1) ^ 16'hb400 : lf >> 1;
      return lf;
   endfunction
   function [15:0] oc(input [15:0] a, b);
      logic [16:0] t;
      t = a + b;
      return t[15:0] + 16'(t[16]);
   endfunction
   function [31:0] wd(input int w, input e);
      for (int b = 3; b >= 0; b--)
         wd = {wd[23:0], e ? ex[4 * w + b] : fr[4 * w + b]};
   endfunction
   function [3:0] sk(input int w, n);
      return (4 * w + 4 > n) ? 4'hf >> (4 * w + 4 - n) : 4'hf;
   endfunction
   function [36:0] msk(input l, input [3:0] k, input [31:0] d);
      return {l, k, d & {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}}};
   endfunction

   wire [2:0] rdy = {s_rxd_tready_o, s_txd_tready_o, s_ctl_tready_o};
   wire [36:0] tx_w = msk(m_txd_tlast_o, m_txd_tstrb_o, m_txd_tdata_o);
   wire [36:0] rx_w = msk(m_rxd_tlast_o, m_rxd_tstrb_o, m_rxd_tdata_o);
   wire [36:0] st_w = msk(m_sts_tlast_o, m_sts_tstrb_o, m_sts_tdata_o);

   stream_checksum_offload #(.ADDR_W(4)) i_dut (
      .*, .s_ctl_tstrb_i(4'hf)
   );
   stream_sink_model i_sink (
      .clk_i, .slow_i(slow), .txd_rdy_o(m_txd_tready_i),
      .rxd_rdy_o(m_rxd_tready_i), .sts_rdy_o(m_sts_tready_i)
   );

   always #5 clk_i = ~clk_i;

   task chk(input [36:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   always @(posedge clk_i) begin
      if ((m_txd_tvalid_o & m_txd_tready_i) === 1'h1) begin
         chk(tx_w, tq.size() ? tq.pop_front() : 'x);
      end
      if ((m_rxd_tvalid_o & m_rxd_tready_i) === 1'h1) begin
         chk(rx_w, rq.size() ? rq.pop_front() : 'x);
      end
      if ((m_sts_tvalid_o & m_sts_tready_i) === 1'h1) begin
         chk(st_w, sq.size() ? sq.pop_front() : 'x);
      end
   end

   task complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge clk_i);
      if (w && a == 8'h00) en = d[1:0];
   endtask

   task fin();
      {s_ctl_tvalid_i, s_txd_tvalid_i, s_rxd_tvalid_i} <= 3'h0;
      @(posedge clk_i);
   endtask

   // Pauses at random between words so the design sees valid drop.
   task put(input int s, input [31:0] d, input [3:0] k, input l);
      if (rnd() > 16'hc000) fin();
      case (s)
         0: {s_ctl_tvalid_i, s_ctl_tdata_i, s_ctl_tlast_i} <= {1'h1, d, l};
         1: {s_txd_tvalid_i, s_txd_tdata_i, s_txd_tstrb_i, s_txd_tlast_i} <=
            {1'h1, d, k, l};
         default: {s_rxd_tvalid_i, s_rxd_tdata_i, s_rxd_tstrb_i,
            s_rxd_tlast_i} <= {1'h1, d, k, l};
      endcase
      do @(posedge clk_i); while (rdy[s] !== 1'h1);
   endtask

   task mk(input int n, st, input [7:0] pr, output [15:0] s);
      for (int i = 0; i < 64; i++) fr[i] = 8'(rnd());
      fr[12] = 8'h08;
      fr[13] = 8'h00;
      fr[23] = pr;
      s = 16'h0;
      for (int i = st; i < n; i += 2)
         s = oc(s, {fr[i], i + 1 < n ? fr[i + 1] : 8'h00});
      ex = fr;
   endtask

   task tx(input [3:0] tag, input [1:0] sel, input [15:0] st, ins,
      input int n, input [7:0] pr, input z);
      logic [15:0] s, sd;
      logic [31:0] cw[0:5];
      int nw;
      nw = (n + 3) / 4;
      mk(n, st, pr, s);
      sd = z ? ~s : rnd();
      s = ~oc(s, sd);
      if (pr == 8'h11 && s == 16'h0) s = 16'hffff;
      if (tag == 4'ha && sel == 2'h1 && en[0]) begin
         ex[ins] = s[15:8];
         ex[ins + 1] = s[7:0];
      end
      cw = '{{tag, 28'h0}, {rnd(), 14'h0, sel}, {st, ins}, {rnd(), sd},
         32'h0, 32'h0};
      for (int i = 0; i < 6; i++) put(0, cw[i], 4'hf, i == 5);
      fin();
      if (tag == 4'ha || tag == 4'h5) begin
         for (int w = 0; w < nw; w++) begin
            tq.push_back(msk(w == nw - 1, sk(w, n), wd(w, 1)));
            put(1, wd(w, 0), sk(w, n), w == nw - 1);
         end
         fin();
      end
      $display("tx test tag %h select %h done", tag, sel);
   endtask

   task rx(input int n);
      logic [15:0] s;
      int nw;
      nw = (n + 3) / 4;
      mk(n, 14, 8'h11, s);
      if (!en[1]) s = 16'h0;
      for (int i = 0; i < 6; i++)
         sq.push_back(msk(i == 5, 4'hf, i == 0 ? 32'h5000_0000 :
            i == 1 ? {16'h0, s} : i == 2 ? 32'(n) : 32'h0));
      for (int w = 0; w < nw; w++) begin
         rq.push_back(msk(w == nw - 1, sk(w, n), wd(w, 0)));
         put(2, wd(w, 0), sk(w, n), w == nw - 1);
      end
      fin();
      $display("rx test of %0d bytes done", n);
   endtask

   task drain();
      while (tq.size() + rq.size() + sq.size() > 0) @(posedge clk_i);
   endtask

   initial begin
      logic [31:0] q;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      wb(1'h0, 8'h00, 32'h0, q);
      chk({5'h0, q}, 37'h3);
      wb(1'h0, 8'h40, 32'h0, q);
      chk({5'h0, q}, 37'h0);
      $display("register test done");
      for (int c = 0; c < 4; c++)
         tx(4'ha, 2'(c), 16'h0022, 16'h0032, 60, 8'h06, 1'h0);
      tx(4'h3, 2'h1, 16'h0022, 16'h0032, 60, 8'h06, 1'h0);
      tx(4'h5, 2'h1, 16'h0022, 16'h0032, 64, 8'h06, 1'h0);
      slow <= 1'h1;
      tx(4'ha, 2'h1, 16'h000e, 16'h0028, 45, 8'h11, 1'h1);
      tx(4'ha, 2'h1, 16'h000e, 16'h0028, 46, 8'h06, 1'h1);
      rx(45);
      rx(64);
      drain();
      wb(1'h1, 8'h00, 32'h0, q);
      tx(4'ha, 2'h1, 16'h0022, 16'h0032, 47, 8'h06, 1'h0);
      rx(23);
      drain();
      complete_run();
   end

   initial begin
      repeat (30000) @(posedge clk_i);
      n_fail++;
      complete_run();
   end
endmodule
